// ---- quasi_bidir_port_pins.sv ----
// quasi-bidirectional ports 1..3 with alternate-function routing
`timescale 1ns/1ps
// Contract
// RULE1 - upper-address port resets high, weak pull-up
// RULE2 - third port resets all ones, weak
// RULE3 - weak high pin reads external level
// RULE4 - written zero holds strong pull-down
// RULE5 - zero-to-one write pulses strong high driver
// RULE6 - upper port outputs address high byte
// RULE7 - port1 bits0-3 timer2 and serial one
// RULE8 - port1 bits4-7 edge-detected extra interrupts
// RULE9 - port3 bits0-5 serial zero, irqs, timers
// RULE10 - port3 bits6,7 write and read strobes
// RULE11 - select pin low forces external program
// RULE12 - internal data memory stays accessible
// RULE13 - config bit picks crystal load
// RULE14 - port1 resets all ones, weak
// RULE15 - software keeps latch one for alternates
module quasi_bidir_port_pins (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire qbp_pkg::port_wr_t   p1_wr,
    input  wire qbp_pkg::port_wr_t   p2_wr,
    input  wire qbp_pkg::port_wr_t   p3_wr,
    input  wire logic [7:0]          p1_pin_in,
    input  wire logic [7:0]          p2_pin_in,
    input  wire logic [7:0]          p3_pin_in,
    input  wire logic                ext_addr_phase,
    input  wire logic [7:0]          upper_address_byte,
    input  wire logic                ext_data_wr,
    input  wire logic                ext_data_rd,
    input  wire logic                timer_two_out,
    input  wire logic                timer_two_out_en,
    input  wire logic                serial_one_tx,
    input  wire logic                serial_zero_tx,
    input  wire logic                external_program_select,
    input  wire logic                xtal_load_wr,
    input  wire logic                xtal_load_data,
    output qbp_pkg::pin_drive_t      p1_drive,
    output qbp_pkg::pin_drive_t      p2_drive,
    output qbp_pkg::pin_drive_t      p3_drive,
    output logic [7:0]               p1_read,
    output logic [7:0]               p2_read,
    output logic [7:0]               p3_read,
    output logic                     timer_two_ext_io,
    output logic                     timer_two_capture_trigger,
    output logic                     serial_one_rx_pin,
    output logic                     extra_irq_a_rising,
    output logic                     extra_irq_b_falling,
    output logic                     extra_irq_c_rising,
    output logic                     extra_irq_d_falling,
    output logic                     serial_zero_rx_pin,
    output logic                     ext_irq_zero_pin,
    output logic                     ext_irq_one_pin,
    output logic                     timer_zero_count_input,
    output logic                     timer_one_count_input,
    output logic                     fetch_external,
    output logic                     internal_data_enable,
    output logic                     timekeeping_load_12p5
);
    // ----------------------------------------
    // port latches and boost counters
    // ----------------------------------------
    logic [7:0]  latch_q   [3];
    logic [7:0]  latch_d   [3];
    logic [3:0]  boost_q   [3][8];
    logic [3:0]  boost_d   [3][8];
    logic [7:0]  wr_data   [3];
    logic [2:0]  wr_en;
    logic [7:0]  alt_force_low [3];
    logic [7:0]  alt_force_high[3];
    logic [7:0]  pin_raw   [3];
    logic [7:0]  s1_q [3];
    logic [7:0]  s2_q [3];
    logic [7:0]  s3_q [3];
    logic [7:0]  clean_q [3];
    logic [7:0]  clean_d [3];
    logic [7:0]  p1_prev_q;
    qbp_pkg::pin_drive_t drive_d [3];
    qbp_pkg::pin_drive_t drive_q [3];
    logic        ea_s1_q, ea_s2_q, ea_s3_q, ea_clean_q;
    logic        xtal_q;

    assign wr_en   = {p3_wr.we, p2_wr.we, p1_wr.we};
    assign wr_data[0] = p1_wr.data;
    assign wr_data[1] = p2_wr.data;
    assign wr_data[2] = p3_wr.data;
    assign pin_raw[0] = p1_pin_in;
    assign pin_raw[1] = p2_pin_in;
    assign pin_raw[2] = p3_pin_in;

    // ----------------------------------------
    // alternate-function drive overrides
    // ----------------------------------------
    // alternates act only through the open latch; software keeps it at one
    // RULE15 latch-one reliance
    logic [7:0] p2_addr_low, p2_addr_high;
    // RULE6 address high byte
    assign p2_addr_low  = ext_addr_phase ? ~upper_address_byte : 8'h00;
    assign p2_addr_high = ext_addr_phase ?  upper_address_byte : 8'h00;
    // RULE7 timer two and serial one outputs
    assign alt_force_low[0]  = {4'h0, ~serial_one_tx, 2'b00, timer_two_out_en & ~timer_two_out};
    assign alt_force_high[0] = 8'h00;
    assign alt_force_low[1]  = p2_addr_low;
    assign alt_force_high[1] = p2_addr_high;
    // RULE10 strobes active low
    assign alt_force_low[2]  = {ext_data_rd, ext_data_wr, 4'h0, ~serial_zero_tx, 1'b0};
    assign alt_force_high[2] = 8'h00;

    // ----------------------------------------
    // per-port, per-bit drive logic
    // ----------------------------------------
    for (genvar p = 0; p < 3; p++) begin : g_port
        for (genvar b = 0; b < 8; b++) begin : g_bit
            logic rising_wr;
            // RULE4 zero held until one written
            assign latch_d[p][b] = wr_en[p] ? wr_data[p][b] : latch_q[p][b];
            assign rising_wr = wr_en[p] & wr_data[p][b] & ~latch_q[p][b];
            // RULE5 momentary strong high
            assign boost_d[p][b] = rising_wr ? qbp_pkg::BOOST_CYCLES :
                                   (boost_q[p][b] != 4'h0) ? boost_q[p][b] - 4'h1 : 4'h0;
            assign drive_d[p].strong_low[b]  = ~latch_d[p][b] | alt_force_low[p][b];
            assign drive_d[p].strong_high[b] = ((boost_d[p][b] != 4'h0) | alt_force_high[p][b])
                                               & ~drive_d[p].strong_low[b];
            assign drive_d[p].weak_up[b]     = ~drive_d[p].strong_low[b];
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    boost_q[p][b] <= 4'h0;
                end else begin
                    boost_q[p][b] <= boost_d[p][b];
                end
            end
        end
        // four-cycle read latency is the price of ignoring one-cycle pin noise
        // RULE3 three-stage pin sampling
        assign clean_d[p] = (s2_q[p] == s3_q[p]) ? s3_q[p] : clean_q[p];
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                // RULE1 RULE2 RULE14 reset all ones
                latch_q[p] <= qbp_pkg::PORT_RESET;
                drive_q[p] <= '{strong_low: 8'h00, strong_high: 8'h00, weak_up: 8'hff};
                s1_q[p]    <= qbp_pkg::PORT_RESET;
                s2_q[p]    <= qbp_pkg::PORT_RESET;
                s3_q[p]    <= qbp_pkg::PORT_RESET;
                clean_q[p] <= qbp_pkg::PORT_RESET;
            end else begin
                latch_q[p] <= latch_d[p];
                drive_q[p] <= drive_d[p];
                s1_q[p]    <= pin_raw[p];
                s2_q[p]    <= s1_q[p];
                s3_q[p]    <= s2_q[p];
                clean_q[p] <= clean_d[p];
            end
        end
    end

    assign p1_drive = drive_q[0];
    assign p2_drive = drive_q[1];
    assign p3_drive = drive_q[2];
    assign p1_read  = clean_q[0];
    assign p2_read  = clean_q[1];
    assign p3_read  = clean_q[2];

    // ----------------------------------------
    // alternate inputs, edge detect, straps
    // ----------------------------------------
    logic [7:0] p1_c;
    logic [7:0] p3_c;
    assign p1_c = clean_q[0];
    assign p3_c = clean_q[2];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // history starts at the idle high level so release gives no false edge
            p1_prev_q                 <= qbp_pkg::PORT_RESET;
            timer_two_ext_io          <= 1'b1;
            timer_two_capture_trigger <= 1'b1;
            serial_one_rx_pin         <= 1'b1;
            extra_irq_a_rising        <= 1'b0;
            extra_irq_b_falling       <= 1'b0;
            extra_irq_c_rising        <= 1'b0;
            extra_irq_d_falling       <= 1'b0;
            serial_zero_rx_pin        <= 1'b1;
            ext_irq_zero_pin          <= 1'b1;
            ext_irq_one_pin           <= 1'b1;
            timer_zero_count_input    <= 1'b1;
            timer_one_count_input     <= 1'b1;
        end else begin
            p1_prev_q                 <= p1_c;
            // RULE7 alternate inputs
            timer_two_ext_io          <= p1_c[qbp_pkg::P1_T2_IO];
            timer_two_capture_trigger <= p1_c[qbp_pkg::P1_T2_TRIG];
            serial_one_rx_pin         <= p1_c[qbp_pkg::P1_S1_RX];
            // RULE8 edge-detect pulses
            extra_irq_a_rising        <= p1_c[4] & ~p1_prev_q[4];
            extra_irq_b_falling       <= ~p1_c[5] & p1_prev_q[5];
            extra_irq_c_rising        <= p1_c[6] & ~p1_prev_q[6];
            extra_irq_d_falling       <= ~p1_c[7] & p1_prev_q[7];
            // RULE9 third-port inputs
            serial_zero_rx_pin        <= p3_c[qbp_pkg::P3_S0_RX];
            ext_irq_zero_pin          <= p3_c[qbp_pkg::P3_IRQ0];
            ext_irq_one_pin           <= p3_c[qbp_pkg::P3_IRQ1];
            timer_zero_count_input    <= p3_c[qbp_pkg::P3_T0];
            timer_one_count_input     <= p3_c[qbp_pkg::P3_T1];
        end
    end

    // strap sampled through the synchroniser so a bouncing tie cannot glitch fetch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ea_s1_q    <= 1'b1;
            ea_s2_q    <= 1'b1;
            ea_s3_q    <= 1'b1;
            ea_clean_q <= 1'b1;
        end else begin
            ea_s1_q <= external_program_select;
            ea_s2_q <= ea_s1_q;
            ea_s3_q <= ea_s2_q;
            if (ea_s2_q == ea_s3_q) begin
                ea_clean_q <= ea_s3_q;
            end
        end
    end

    // RULE11 low selects external program
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fetch_external       <= 1'b0;
            internal_data_enable <= 1'b1;
        end else begin
            fetch_external       <= ~ea_clean_q;
            // RULE12 internal data stays on
            internal_data_enable <= 1'b1;
        end
    end

    // RULE13 crystal load select
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xtal_q <= qbp_pkg::XTAL_LOAD_RESET;
        end else if (xtal_load_wr) begin
            xtal_q <= xtal_load_data;
        end
    end
    assign timekeeping_load_12p5 = xtal_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_zero_pulls_low: assert property ( // RULE4
        p1_wr.we && !p1_wr.data[0] |=> p1_drive.strong_low[0] && !p1_drive.weak_up[0])
        else $error("written zero did not pull low");
    a_boost_pulse: assert property ( // RULE5
        p3_wr.we && p3_wr.data[4] && !latch_q[2][4] |=> p3_drive.strong_high[4] ##1 !p3_drive.strong_high[4])
        else $error("boost pulse length wrong");
    a_weak_hold: assert property ( // RULE5
        p2_wr.we && p2_wr.data[1] && latch_q[1][1] && !ext_addr_phase
        |=> !p2_drive.strong_high[1] && p2_drive.weak_up[1])
        else $error("boost on a bit already high");
    a_addr_drive: assert property ( // RULE6
        ext_addr_phase && upper_address_byte[3] && latch_q[1][3] && !(p2_wr.we && !p2_wr.data[3])
        |=> !p2_drive.strong_low[3])
        else $error("address one pulled low");
    a_addr_zero: assert property ( // RULE6
        ext_addr_phase && !upper_address_byte[5] |=> p2_drive.strong_low[5])
        else $error("address zero not driven");
    a_wr_strobe: assert property ( // RULE10
        ext_data_wr |=> p3_drive.strong_low[qbp_pkg::P3_WR])
        else $error("write strobe missing");
    a_rise_irq: assert property ( // RULE8
        extra_irq_a_rising |-> $past(p1_c[4]) && !$past(p1_prev_q[4]))
        else $error("rising irq without edge");
    a_fall_irq: assert property ( // RULE8
        $fell(p1_c[5]) |=> extra_irq_b_falling)
        else $error("falling edge missed");
    a_pin_read: assert property ( // RULE3
        $stable(p3_pin_in)[*4] |=> p3_read == $past(p3_pin_in, 4))
        else $error("pin level not read");
    a_ea_fetch: assert property ( // RULE11
        (ea_clean_q == 1'b0)[*2] |-> fetch_external)
        else $error("external fetch not selected");

    a_rd_strobe: assert property ( // RULE10
        ext_data_rd |=> p3_drive.strong_low[qbp_pkg::P3_RD])
        else $error("read strobe missing");
    a_tx_one: assert property ( // RULE7
        !serial_one_tx |=> p1_drive.strong_low[qbp_pkg::P1_S1_TX])
        else $error("serial one tx low not driven");
    a_tx_zero: assert property ( // RULE9
        !serial_zero_tx |=> p3_drive.strong_low[qbp_pkg::P3_S0_TX])
        else $error("serial zero tx low not driven");
    // a held level must not re-arm the interrupt every cycle
    a_irq_single: assert property ( // RULE8
        extra_irq_c_rising |=> !extra_irq_c_rising)
        else $error("rising irq pulse longer than one cycle");

    c_boost: cover property (p1_wr.we && p1_wr.data[0] && !latch_q[0][0]);
    c_addr:  cover property (ext_addr_phase ##1 ext_data_rd);
    c_irq:   cover property (extra_irq_d_falling);
    c_ext_fetch: cover property (fetch_external);
    c_pin_low:   cover property (p3_read != 8'hff);
endmodule // quasi_bidir_port_pins

// ---- qbp_pkg.sv ----
// shared constants and carrier types for the quasi-bidirectional port block
package qbp_pkg;
    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic [7:0] PORT_RESET     = 8'hff;
    localparam int         CLK_HZ         = 10_000_000;
    // strong transition driver pulse after a zero-to-one write (least time)
    localparam int         BOOST_NS       = 100;
    localparam int         BOOST_CYCLES_R = (BOOST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] BOOST_CYCLES   = 4'((BOOST_CYCLES_R < 1) ? 1 : BOOST_CYCLES_R);
    localparam logic       XTAL_LOAD_RESET = 1'b0;  // 0: 6 pF, 1: 12.5 pF

    // ----------------------------------------
    // bit positions of shared functions
    // ----------------------------------------
    localparam int P1_T2_IO   = 0;
    localparam int P1_T2_TRIG = 1;
    localparam int P1_S1_RX   = 2;
    localparam int P1_S1_TX   = 3;
    localparam int P3_S0_RX   = 0;
    localparam int P3_S0_TX   = 1;
    localparam int P3_IRQ0    = 2;
    localparam int P3_IRQ1    = 3;
    localparam int P3_T0      = 4;
    localparam int P3_T1      = 5;
    localparam int P3_WR      = 6;
    localparam int P3_RD      = 7;

    // per-port pin drive: strong low, strong high pulse, weak pull-up enable
    typedef struct packed {
        logic [7:0] strong_low;
        logic [7:0] strong_high;
        logic [7:0] weak_up;
    } pin_drive_t;

    // one port write from the core
    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } port_wr_t;
endpackage

// ---- qbp_board.sv ----
// board model that resolves the port pins from device drive and external pull-downs
`timescale 1ns/1ps
module qbp_board (
    input  wire qbp_pkg::pin_drive_t drv,
    input  wire logic [7:0]          ext_low,
    output logic [7:0]               pin
);
    // external low beats pull-up
    // a released pin floats back high through the weak pull-up; the strong high driver wins
    assign pin = ~(drv.strong_low | (ext_low & ~drv.strong_high));
endmodule // qbp_board

// ---- tb.sv ----
// self-checking bench for the quasi-bidirectional port block
`timescale 1ns/1ps
module tb;
    logic                clk, nrst;
    qbp_pkg::port_wr_t   p1_wr, p2_wr, p3_wr;
    logic [7:0]          p1_pin_in, p2_pin_in, p3_pin_in, e1, e2, e3, upper_address_byte;
    logic                ext_addr_phase, ext_data_wr, ext_data_rd, timer_two_out;
    logic                timer_two_out_en, serial_one_tx, serial_zero_tx;
    logic                external_program_select, xtal_load_wr, xtal_load_data;
    qbp_pkg::pin_drive_t p1_drive, p2_drive, p3_drive;
    logic [7:0]          p1_read, p2_read, p3_read;
    logic                timer_two_ext_io, timer_two_capture_trigger, serial_one_rx_pin;
    logic                extra_irq_a_rising, extra_irq_b_falling, extra_irq_c_rising;
    logic                extra_irq_d_falling, serial_zero_rx_pin, ext_irq_zero_pin;
    logic                ext_irq_one_pin, timer_zero_count_input, timer_one_count_input;
    logic                fetch_external, internal_data_enable, timekeeping_load_12p5;
    int                  error_cnt, compares, cyc, na, nb, nc, nd;

    quasi_bidir_port_pins i_dut (.clk, .nrst, .p1_wr, .p2_wr, .p3_wr, .p1_pin_in, .p2_pin_in,
        .p3_pin_in, .ext_addr_phase, .upper_address_byte, .ext_data_wr, .ext_data_rd,
        .timer_two_out, .timer_two_out_en, .serial_one_tx, .serial_zero_tx,
        .external_program_select, .xtal_load_wr, .xtal_load_data, .p1_drive, .p2_drive,
        .p3_drive, .p1_read, .p2_read, .p3_read, .timer_two_ext_io, .timer_two_capture_trigger,
        .serial_one_rx_pin, .extra_irq_a_rising, .extra_irq_b_falling, .extra_irq_c_rising,
        .extra_irq_d_falling, .serial_zero_rx_pin, .ext_irq_zero_pin, .ext_irq_one_pin,
        .timer_zero_count_input, .timer_one_count_input, .fetch_external,
        .internal_data_enable, .timekeeping_load_12p5);
    qbp_board i_b1 (.drv(p1_drive), .ext_low(e1), .pin(p1_pin_in));
    qbp_board i_b2 (.drv(p2_drive), .ext_low(e2), .pin(p2_pin_in));
    qbp_board i_b3 (.drv(p3_drive), .ext_low(e3), .pin(p3_pin_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one-cycle write pulse; returns just after the edge that took it
    task automatic wr(input int p, input logic [7:0] v);
        @(posedge clk);
        if (p == 1) p1_wr <= '{1'b1, v};
        else if (p == 2) p2_wr <= '{1'b1, v};
        else p3_wr <= '{1'b1, v};
        @(posedge clk);
        p1_wr.we <= 1'b0;
        p2_wr.we <= 1'b0;
        p3_wr.we <= 1'b0;
        #1;
    endtask

    always @(posedge clk) begin
        na <= na + int'(extra_irq_a_rising);
        nb <= nb + int'(extra_irq_b_falling);
        nc <= nc + int'(extra_irq_c_rising);
        nd <= nd + int'(extra_irq_d_falling);
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk(p1_drive.weak_up, 8'hff);
        chk(p1_drive.strong_low, 8'h00);
        chk(p2_drive.weak_up, 8'hff);
        chk(p2_drive.strong_low, 8'h00);
        chk(p3_drive.weak_up, 8'hff);
        chk(p3_drive.strong_low, 8'h00);
        chk(p3_read, 8'hff);
        chk(8'(timekeeping_load_12p5), 8'h00);
    endtask
    task automatic t_latch();
        wr(1, 8'hfe);
        chk(p1_drive.strong_low, 8'h01);
        wr(3, 8'hef);
        chk(p3_drive.strong_low, 8'h10);
        wr(1, 8'hff);
        chk(p1_drive.strong_high, 8'h01);
        wr(3, 8'hff);
        chk(p3_drive.strong_high, 8'h10);
        wr(2, 8'h5a);
        chk(p2_drive.strong_low, 8'ha5);
        chk(p2_drive.strong_high, 8'h00);
        cyc_n(6);
        chk(p2_read, 8'h5a);
        chk(p2_drive.strong_low, 8'ha5);
        wr(2, 8'hff);
        chk(p2_drive.strong_high, 8'ha5);
        chk(p2_drive.strong_low, 8'h00);
        cyc_n(1);
        chk(p2_drive.strong_high, 8'h00);
        chk(p2_drive.weak_up, 8'hff);
    endtask
    task automatic t_input();
        @(posedge clk);
        e3 <= 8'h3d;
        cyc_n(6);
        chk(p3_read, 8'hc2);
        chk({3'h0, serial_zero_rx_pin, ext_irq_zero_pin, ext_irq_one_pin,
             timer_zero_count_input, timer_one_count_input}, 8'h00);
        e3 <= 8'h00;
        cyc_n(6);
        chk({3'h0, serial_zero_rx_pin, ext_irq_zero_pin, ext_irq_one_pin,
             timer_zero_count_input, timer_one_count_input}, 8'h1f);
    endtask
    task automatic t_addr();
        @(posedge clk);
        ext_addr_phase <= 1'b1;
        upper_address_byte <= 8'hce;
        cyc_n(2);
        chk(p2_drive.strong_high, 8'hce);
        chk(p2_drive.strong_low, 8'h31);
        ext_addr_phase <= 1'b0;
    endtask
    task automatic t_alt();
        @(posedge clk);
        serial_one_tx <= 1'b0;
        timer_two_out_en <= 1'b1;
        timer_two_out <= 1'b0;
        serial_zero_tx <= 1'b0;
        ext_data_wr <= 1'b1;
        e1 <= 8'h06;
        cyc_n(6);
        chk(p1_drive.strong_low, 8'h09);
        chk({5'h0, timer_two_ext_io, timer_two_capture_trigger, serial_one_rx_pin},
            8'h00);
        chk(p3_drive.strong_low, 8'h42);
        chk(p1_read, 8'hf0);
        ext_data_wr <= 1'b0;
        ext_data_rd <= 1'b1;
        cyc_n(2);
        chk(p3_drive.strong_low, 8'h82);
        ext_data_rd <= 1'b0;
        serial_one_tx <= 1'b1;
        serial_zero_tx <= 1'b1;
        timer_two_out_en <= 1'b0;
        e1 <= 8'h00;
        cyc_n(6);
    endtask
    task automatic t_irq();
        e1 <= 8'hf0;
        cyc_n(8);
        chk({2'(na), 2'(nb), 2'(nc), 2'(nd)}, 8'h11);
        e1 <= 8'h00;
        cyc_n(8);
        chk({2'(na), 2'(nb), 2'(nc), 2'(nd)}, 8'h55);
    endtask
    task automatic t_strap();
        external_program_select <= 1'b0;
        xtal_load_wr <= 1'b1;
        xtal_load_data <= 1'b1;
        cyc_n(1);
        xtal_load_wr <= 1'b0;
        cyc_n(6);
        chk(8'(fetch_external), 8'h01);
        chk(8'(internal_data_enable), 8'h01);
        chk(8'(timekeeping_load_12p5), 8'h01);
        external_program_select <= 1'b1;
        cyc_n(6);
        chk(8'(fetch_external), 8'h00);
    endtask

    initial begin
        nrst = 1'b0;
        {p1_wr, p2_wr, p3_wr, e1, e2, e3, upper_address_byte} = '0;
        {ext_addr_phase, ext_data_wr, ext_data_rd, timer_two_out_en} = '0;
        {xtal_load_wr, xtal_load_data} = '0;
        {timer_two_out, serial_one_tx, serial_zero_tx, external_program_select} = 4'hf;
        {error_cnt, compares, cyc, na, nb, nc, nd} = '0;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        nrst <= 1'b1;
        t_latch();
        t_input();
        t_addr();
        t_alt();
        t_irq();
        t_strap();
        end_sim();
    end
endmodule // tb
